// ### pkg/rcs_pkg.sv
// Constants for the reset and clock source controller
package rcs_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] SUPPLY_CTL_OFS  = 8'h00;
  localparam logic [7:0] REGULATOR_OFS   = 8'h04;
  localparam logic [7:0] CAUSE_OFS       = 8'h08;
  localparam logic [7:0] CLK_CFG_OFS     = 8'h0C;
  localparam logic [7:0] SOFT_RST0_OFS   = 8'h10;
  localparam logic [7:0] WDOG_LOAD_OFS   = 8'h1C;
  localparam logic [7:0] WDOG_CTL_OFS    = 8'h20;
  localparam logic [7:0] WDOG_CLR_OFS    = 8'h24;
  localparam logic [7:0] STATUS_OFS      = 8'h28;
  localparam logic [7:0] WDOG_VAL_OFS    = 8'h2C;

  // Supply reset control fields
  localparam int WAIT_RESAMPLE_BIT = 0;
  localparam int RESET_SELECT_BIT  = 1;
  localparam int DELAY_LSB         = 2;
  localparam int DELAY_W           = 14;
  localparam int DROOP_IRQ_EN_BIT  = 16;
  localparam int DROOP_FILT_EN_BIT = 17;
  localparam logic [31:0] SUPPLY_CTL_RST = 32'h0000_0000;

  // Regulator control fields
  localparam int REG_RST_EN_BIT = 0;
  localparam logic [31:0] REGULATOR_RST = 32'h0000_0000;

  // Reset cause bits
  localparam int CAUSE_EXT   = 0;
  localparam int CAUSE_POR   = 1;
  localparam int CAUSE_DROOP = 2;
  localparam int CAUSE_SW    = 3;
  localparam int CAUSE_WDOG  = 4;
  localparam int CAUSE_REG   = 5;
  localparam int CAUSE_W     = 6;
  localparam logic [5:0] CAUSE_RST = 6'h02;

  // Clock configuration fields
  localparam int SRC_LSB    = 4;
  localparam int BYPASS_BIT = 11;
  localparam logic [31:0] CLK_CFG_RST = 32'h0000_0800;
  localparam logic [1:0] SRC_MAIN = 2'h0;
  localparam logic [1:0] SRC_RC   = 2'h1;
  localparam logic [1:0] SRC_RC4  = 2'h2;
  localparam logic [1:0] SRC_PLL  = 2'h3;

  // Watchdog control and status fields
  localparam int WDOG_EN_BIT    = 0;
  localparam int WDOG_RSTEN_BIT = 1;
  localparam int ST_DROOP_IRQ   = 0;
  localparam int ST_DROOP_COND  = 1;
  localparam int ST_WDOG_IRQ    = 2;
  localparam logic [31:0] WDOG_LOAD_RST = 32'hFFFF_FFFF;

  // Timing
  localparam int CLK_KHZ         = 40000;
  localparam int DROOP_HOLD_US   = 500;
  localparam int DROOP_HOLD_CYC  = (DROOP_HOLD_US * CLK_KHZ) / 1000;
  localparam int RST_PULSE_CYC   = 16;
  localparam int DROOP_FILT_CYC  = 8;

  typedef enum logic [1:0] {DROOP_IDLE, DROOP_WAIT, DROOP_HOLD} rcs_droop_e;
endpackage

// ### rtl/rcs_rst_sync.sv
// Reset synchroniser: asynchronous assert, synchronous release per bit
`timescale 1ns/1ps
module rcs_rst_sync #(
  parameter int WIDTH = 1
) (
  // Clock and power-on reset
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  // Reset requests, active high
  input  wire logic [WIDTH-1:0] req_i,
  // Synchronised resets
  output logic      [WIDTH-1:0] rst_n_o
);
  generate
    if (WIDTH < 1)
    begin : g_chk
      $error("rcs_rst_sync: WIDTH must be at least 1");
    end
    for (genvar k = 0; k < WIDTH; k++)
    begin : g_bit
      logic clr_n;
      logic s1_ff;
      logic s2_ff;
      assign clr_n = arst_n_i & ~req_i[k];
      always_ff @(posedge clk_i or negedge clr_n)
      begin
        if (!clr_n)
        begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
        end
        else
        begin
          s1_ff <= 1'b1;
          s2_ff <= s1_ff;
        end
      end
      assign rst_n_o[k] = s2_ff;
    end
  endgenerate
endmodule

// ### rtl/rcs_clk_switch.sv
// Glitch-free clock multiplexer over N free-running sources
`timescale 1ns/1ps
module rcs_clk_switch #(
  parameter int N = 4
) (
  // Sources and reset
  input  wire logic                 arst_n_i,
  input  wire logic [N-1:0]         src_clk_i,
  // Selection, from the control domain
  input  wire logic [$clog2(N)-1:0] sel_i,
  // Switched clock
  output logic                      clk_o
);
  logic [N-1:0] en;

  generate
    if (N < 2)
    begin : g_chk
      $error("rcs_clk_switch: N must be at least 2");
    end
    for (genvar k = 0; k < N; k++)
    begin : g_src
      logic req;
      logic s1_ff;
      logic s2_ff;
      logic en_ff;
      // Only start once every other source has stopped
      assign req = (sel_i == ($clog2(N))'(k)) & ~|(en & ~(N'(1) << k));
      always_ff @(posedge src_clk_i[k] or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
        end
        else
        begin
          s1_ff <= req;
          s2_ff <= s1_ff;
        end
      end
      // Enable changes only while the source is low
      always_ff @(negedge src_clk_i[k] or negedge arst_n_i)
      begin
        if (!arst_n_i)
          en_ff <= 1'b0;
        else
          en_ff <= s2_ff;
      end
      assign en[k] = en_ff;
    end
  endgenerate

  assign clk_o = |(src_clk_i & en);
endmodule

// ### rtl/rcs_ctrl.sv
// Reset source and system clock source controller
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
module rcs_ctrl #(
  parameter int NUM_SOFT = 3,
  parameter int NUM_DOM  = 2,
  parameter int HOLD_CYC = rcs_pkg::DROOP_HOLD_CYC,
  parameter int PULSE    = rcs_pkg::RST_PULSE_CYC,
  parameter int FILT     = rcs_pkg::DROOP_FILT_CYC
) (
  // Clock and power-on reset
  input  wire logic                         core_clk_i,
  input  wire logic                         resetn_i,
  // Register port
  input  wire logic [7:0]                   reg_addr_i,
  input  wire logic [31:0]                  reg_wdata_i,
  input  wire logic                         reg_wr_i,
  input  wire logic                         reg_rd_i,
  output logic      [31:0]                  reg_rdata_o,
  // Reset sources
  input  wire logic                         ext_rstn_i,
  input  wire logic                         droop_det_i,
  input  wire logic                         regulator_unreg_i,
  input  wire logic                         core_system_reset_request_i,
  // Clock sources and system clock
  input  wire logic                         main_crystal_oscillator_i,
  input  wire logic                         internal_rc_oscillator_i,
  input  wire logic                         pll_clk_i,
  output logic [1:0]                        pll_ref_sel_o,
  output logic                              pll_bypass_o,
  output logic                              system_clock_out_o,
  // Peripheral domain clocks and reset outputs
  input  wire logic [NUM_DOM-1:0]           periph_clk_i,
  output logic [NUM_DOM*NUM_SOFT*32-1:0]    periph_rst_n_o,
  output logic                              core_rst_n_o,
  // Events
  output logic                              droop_irq_o,
  output logic                              wdog_irq_o
);
  localparam int HW = $clog2(HOLD_CYC + 1);
  localparam int PW = $clog2(PULSE + 1);
  localparam int FW = $clog2(FILT + 1);
  localparam int NB = NUM_SOFT * 32;

  generate
    if (NUM_SOFT < 1 || NUM_SOFT > 3 || NUM_DOM < 1 || PULSE < 1 || FILT < 1 || HOLD_CYC < 1)
    begin : g_chk
      $error("rcs_ctrl: unsupported parameter value");
    end
  endgenerate

  // Pin inputs: three flops, change accepted when stages two and three agree
  localparam logic [2:0] PIN_IDLE = 3'h1;
  logic [2:0] pin_raw;
  logic [2:0] pin_ok;
  assign pin_raw = {regulator_unreg_i, droop_det_i, ext_rstn_i};
  generate
    for (genvar k = 0; k < 3; k++)
    begin : g_pin
      logic [2:0] sh_ff;
      logic       ok_ff;
      always_ff @(posedge core_clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          sh_ff <= {3{PIN_IDLE[k]}};
          ok_ff <= PIN_IDLE[k];
        end
        else
        begin
          sh_ff <= {sh_ff[1:0], pin_raw[k]};
          ok_ff <= (sh_ff[1] == sh_ff[2]) ? sh_ff[2] : ok_ff;
        end
      end
      assign pin_ok[k] = ok_ff;
    end
  endgenerate
  logic ext_req;
  logic droop_now;
  logic reg_fault;
  assign ext_req   = ~pin_ok[0];
  assign droop_now = pin_ok[1];
  assign reg_fault = pin_ok[2];

  // Registers
  logic [31:0]         supply_reset_control_reg_ff;
  logic [31:0]         regulator_control_reg_ff;
  logic [5:0]          reset_cause_reg_ff;
  logic [31:0]         clk_cfg_ff;
  logic [31:0]         peripheral_soft_reset_regs_ff [NUM_SOFT];
  logic [31:0]         watchdog_reload_value_ff;
  logic [1:0]          wdog_ctl_ff;
  logic [31:0]         wdog_cnt_ff;
  logic                wdog_int_ff;
  logic                droop_irq_ff;
  logic [31:0]         reg_rdata_ff;
  logic                sys_rst_ff;
  logic [PW-1:0]       pulse_ff;

  // Address decode
  logic wr_supply;
  logic wr_reg;
  logic wr_cause;
  logic wr_clk;
  logic wr_load;
  logic wr_wctl;
  logic wr_wclr;
  logic wr_stat;
  logic [7:0] soft_ofs;
  logic [5:0] soft_idx;
  logic soft_hit;
  assign wr_supply = reg_wr_i & (reg_addr_i == rcs_pkg::SUPPLY_CTL_OFS);
  assign wr_reg    = reg_wr_i & (reg_addr_i == rcs_pkg::REGULATOR_OFS);
  assign wr_cause  = reg_wr_i & (reg_addr_i == rcs_pkg::CAUSE_OFS);
  assign wr_clk    = reg_wr_i & (reg_addr_i == rcs_pkg::CLK_CFG_OFS);
  assign wr_load   = reg_wr_i & (reg_addr_i == rcs_pkg::WDOG_LOAD_OFS);
  assign wr_wctl   = reg_wr_i & (reg_addr_i == rcs_pkg::WDOG_CTL_OFS);
  assign wr_wclr   = reg_wr_i & (reg_addr_i == rcs_pkg::WDOG_CLR_OFS);
  assign wr_stat   = reg_wr_i & (reg_addr_i == rcs_pkg::STATUS_OFS);
  assign soft_ofs  = reg_addr_i - rcs_pkg::SOFT_RST0_OFS;
  assign soft_idx  = soft_ofs[7:2];
  assign soft_hit  = (reg_addr_i >= rcs_pkg::SOFT_RST0_OFS) & (soft_ofs[1:0] == 2'h0)
                     & (soft_idx < 6'(NUM_SOFT));

  // Configuration fields
  logic cfg_wait;
  logic cfg_rsel;
  logic cfg_irq_en;
  logic cfg_filt;
  logic [rcs_pkg::DELAY_W-1:0] cfg_delay;
  assign cfg_wait   = supply_reset_control_reg_ff[rcs_pkg::WAIT_RESAMPLE_BIT];
  assign cfg_rsel   = supply_reset_control_reg_ff[rcs_pkg::RESET_SELECT_BIT];
  assign cfg_irq_en = supply_reset_control_reg_ff[rcs_pkg::DROOP_IRQ_EN_BIT];
  assign cfg_filt   = supply_reset_control_reg_ff[rcs_pkg::DROOP_FILT_EN_BIT];
  assign cfg_delay  = supply_reset_control_reg_ff[rcs_pkg::DELAY_LSB +: rcs_pkg::DELAY_W];

  // Supply droop sequencer; its hold survives the reset it causes
  rcs_pkg::rcs_droop_e droop_st_ff;
  rcs_pkg::rcs_droop_e nxt_droop_st;
  logic [HW-1:0]               hold_ff;
  logic [HW-1:0]               nxt_hold;
  logic [rcs_pkg::DELAY_W-1:0] wait_ff;
  logic [rcs_pkg::DELAY_W-1:0] nxt_wait;
  logic                        droop_q_ff;
  logic                        droop_rise;
  logic                        supply_droop_reset;
  assign droop_rise = droop_now & ~droop_q_ff;

  always_comb
  begin
    nxt_droop_st       = droop_st_ff;
    nxt_hold           = hold_ff;
    nxt_wait           = wait_ff;
    supply_droop_reset = 1'b0;
    case (droop_st_ff)
      rcs_pkg::DROOP_IDLE:
        if (droop_rise)
        begin
          nxt_hold = HW'(HOLD_CYC - 1);
          if (cfg_rsel)
          begin
            supply_droop_reset = 1'b1;
            nxt_droop_st       = rcs_pkg::DROOP_HOLD;
          end
          else if (cfg_wait)
          begin
            nxt_wait     = cfg_delay;
            nxt_droop_st = rcs_pkg::DROOP_WAIT;
          end
          else
            nxt_droop_st = rcs_pkg::DROOP_HOLD;
        end
      rcs_pkg::DROOP_WAIT:
        if (wait_ff == '0)
        begin
          supply_droop_reset = droop_now;
          nxt_droop_st       = droop_now ? rcs_pkg::DROOP_HOLD : rcs_pkg::DROOP_IDLE;
        end
        else
          nxt_wait = wait_ff - 1'b1;
      rcs_pkg::DROOP_HOLD:
        if (hold_ff == '0)
          nxt_droop_st = rcs_pkg::DROOP_IDLE;
        else
          nxt_hold = hold_ff - 1'b1;
      default:
        nxt_droop_st = rcs_pkg::DROOP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      droop_st_ff <= rcs_pkg::DROOP_IDLE;
      hold_ff     <= '0;
      wait_ff     <= '0;
      droop_q_ff  <= 1'b0;
    end
    else
    begin
      droop_st_ff <= nxt_droop_st;
      hold_ff     <= nxt_hold;
      wait_ff     <= nxt_wait;
      droop_q_ff  <= droop_now;
    end
  end

  // Droop interrupt path with optional persistence filter
  logic [FW-1:0] filt_ff;
  logic          irq_evt;
  logic          irq_path;
  assign irq_path = cfg_irq_en & ~cfg_rsel & ~cfg_wait;
  assign irq_evt  = irq_path & (cfg_filt ? (droop_now & (filt_ff == FW'(FILT - 1)))
                                         : droop_rise);
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      filt_ff <= '0;
    else if (!droop_now)
      filt_ff <= '0;
    else if (filt_ff != FW'(FILT))
      filt_ff <= filt_ff + 1'b1;
  end

  // Watchdog: interrupt on first zero, reset on second
  logic wdog_en;
  logic wdog_zero;
  logic wdog_first;
  logic wdog_rst;
  assign wdog_en    = wdog_ctl_ff[rcs_pkg::WDOG_EN_BIT];
  assign wdog_zero  = wdog_en & (wdog_cnt_ff == 32'h0000_0000);
  assign wdog_first = wdog_zero & ~wdog_int_ff;
  assign wdog_rst   = wdog_zero & wdog_int_ff & wdog_ctl_ff[rcs_pkg::WDOG_RSTEN_BIT];

  // Regulator fault reset
  logic reg_rst;
  assign reg_rst = reg_fault & regulator_control_reg_ff[rcs_pkg::REG_RST_EN_BIT];

  // System reset request collection
  logic any_rst;
  logic [5:0] cause_set;
  logic [5:0] nxt_cause;
  assign cause_set = {reg_rst, wdog_rst, core_system_reset_request_i, supply_droop_reset,
                      1'b0, ext_req};
  assign any_rst   = |cause_set;
  assign nxt_cause = ext_req ? 6'(1 << rcs_pkg::CAUSE_EXT)
                   : ((wr_cause ? (reset_cause_reg_ff & reg_wdata_i[5:0])
                                : reset_cause_reg_ff) | cause_set);

  // Internal reset pulse: held while requested, then PULSE cycles
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sys_rst_ff         <= 1'b1;
      pulse_ff           <= PW'(PULSE);
      reset_cause_reg_ff <= rcs_pkg::CAUSE_RST;
    end
    else
    begin
      reset_cause_reg_ff <= nxt_cause;
      if (any_rst)
      begin
        sys_rst_ff <= 1'b1;
        pulse_ff   <= PW'(PULSE);
      end
      else if (pulse_ff != '0)
        pulse_ff <= pulse_ff - 1'b1;
      else
        sys_rst_ff <= 1'b0;
    end
  end

  // Software registers; internal reset returns them to defaults
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      supply_reset_control_reg_ff <= rcs_pkg::SUPPLY_CTL_RST;
      regulator_control_reg_ff    <= rcs_pkg::REGULATOR_RST;
      clk_cfg_ff                  <= rcs_pkg::CLK_CFG_RST;
      watchdog_reload_value_ff    <= rcs_pkg::WDOG_LOAD_RST;
      wdog_ctl_ff                 <= 2'h0;
    end
    else if (sys_rst_ff)
    begin
      supply_reset_control_reg_ff <= rcs_pkg::SUPPLY_CTL_RST;
      regulator_control_reg_ff    <= rcs_pkg::REGULATOR_RST;
      clk_cfg_ff                  <= rcs_pkg::CLK_CFG_RST;
      watchdog_reload_value_ff    <= rcs_pkg::WDOG_LOAD_RST;
      wdog_ctl_ff                 <= 2'h0;
    end
    else
    begin
      if (wr_supply)
        supply_reset_control_reg_ff <= reg_wdata_i;
      if (wr_reg)
        regulator_control_reg_ff <= reg_wdata_i;
      if (wr_clk)
        clk_cfg_ff <= reg_wdata_i;
      if (wr_load)
        watchdog_reload_value_ff <= reg_wdata_i;
      if (wr_wctl)
        wdog_ctl_ff <= reg_wdata_i[1:0];
    end
  end

  // Watchdog counter and sticky event flags; set wins over clear
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wdog_cnt_ff  <= rcs_pkg::WDOG_LOAD_RST;
      wdog_int_ff  <= 1'b0;
      droop_irq_ff <= 1'b0;
    end
    else
    begin
      droop_irq_ff <= irq_evt | (droop_irq_ff & ~(wr_stat & reg_wdata_i[rcs_pkg::ST_DROOP_IRQ]));
      if (sys_rst_ff)
      begin
        wdog_cnt_ff <= rcs_pkg::WDOG_LOAD_RST;
        wdog_int_ff <= 1'b0;
      end
      else
      begin
        wdog_int_ff <= wdog_first | (wdog_int_ff & ~wr_wclr);
        if (wr_load)
          wdog_cnt_ff <= reg_wdata_i;
        else if (wdog_zero)
          wdog_cnt_ff <= watchdog_reload_value_ff;
        else if (wdog_en)
          wdog_cnt_ff <= wdog_cnt_ff - 32'h0000_0001;
      end
    end
  end

  // Soft peripheral resets; bit n is the unit in clock gating bit n
  generate
    for (genvar r = 0; r < NUM_SOFT; r++)
    begin : g_soft
      always_ff @(posedge core_clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
          peripheral_soft_reset_regs_ff[r] <= 32'h0000_0000;
        else if (soft_hit & reg_wr_i & (soft_idx == 6'(r)))
          peripheral_soft_reset_regs_ff[r] <= reg_wdata_i;
      end
    end
  endgenerate

  // Unit held in reset while its bit is set, released when cleared
  logic [NB-1:0] soft_req;
  generate
    for (genvar r = 0; r < NUM_SOFT; r++)
    begin : g_req
      assign soft_req[r*32 +: 32] = peripheral_soft_reset_regs_ff[r] | {32{sys_rst_ff}};
    end
    for (genvar d = 0; d < NUM_DOM; d++)
    begin : g_dom
      rcs_rst_sync #(
        .WIDTH (NB)
      ) u_prst (
        .clk_i    (periph_clk_i[d]),
        .arst_n_i (resetn_i),
        .req_i    (soft_req),
        .rst_n_o  (periph_rst_n_o[d*NB +: NB])
      );
    end
  endgenerate

  rcs_rst_sync #(
    .WIDTH (1)
  ) u_core_rst (
    .clk_i    (core_clk_i),
    .arst_n_i (resetn_i),
    .req_i    (sys_rst_ff),
    .rst_n_o  (core_rst_n_o)
  );

  // System clock selection
  logic [1:0] oscillator_source_select;
  logic       bypass;
  logic [1:0] osc_sel;
  logic [1:0] clk_sel;
  logic [1:0] rc_div_ff;
  assign oscillator_source_select = clk_cfg_ff[rcs_pkg::SRC_LSB +: 2];
  assign bypass  = clk_cfg_ff[rcs_pkg::BYPASS_BIT];
  assign osc_sel = (oscillator_source_select == rcs_pkg::SRC_PLL) ? rcs_pkg::SRC_MAIN
                 : oscillator_source_select;
  assign clk_sel = bypass ? osc_sel : rcs_pkg::SRC_PLL;
  assign pll_ref_sel_o = osc_sel;
  assign pll_bypass_o  = bypass;

  always_ff @(posedge internal_rc_oscillator_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rc_div_ff <= 2'h0;
    else
      rc_div_ff <= rc_div_ff + 2'h1;
  end

  rcs_clk_switch #(
    .N (4)
  ) u_clk_sw (
    .arst_n_i  (resetn_i),
    .src_clk_i ({pll_clk_i, rc_div_ff[1], internal_rc_oscillator_i,
                 main_crystal_oscillator_i}),
    .sel_i     (clk_sel),
    .clk_o     (system_clock_out_o)
  );

  // Register read, data in the cycle after the strobe only
  logic [31:0] status;
  logic [31:0] rd_mux;
  logic [31:0] soft_rd;
  assign status  = {29'h0, wdog_int_ff, droop_st_ff != rcs_pkg::DROOP_IDLE, droop_irq_ff};
  assign soft_rd = soft_hit ? peripheral_soft_reset_regs_ff[soft_idx[1:0]] : 32'h0000_0000;
  assign rd_mux  = (reg_addr_i == rcs_pkg::SUPPLY_CTL_OFS) ? supply_reset_control_reg_ff
                 : (reg_addr_i == rcs_pkg::REGULATOR_OFS)  ? regulator_control_reg_ff
                 : (reg_addr_i == rcs_pkg::CAUSE_OFS)      ? {26'h0, reset_cause_reg_ff}
                 : (reg_addr_i == rcs_pkg::CLK_CFG_OFS)    ? clk_cfg_ff
                 : (reg_addr_i == rcs_pkg::WDOG_LOAD_OFS)  ? watchdog_reload_value_ff
                 : (reg_addr_i == rcs_pkg::WDOG_CTL_OFS)   ? {30'h0, wdog_ctl_ff}
                 : (reg_addr_i == rcs_pkg::STATUS_OFS)     ? status
                 : (reg_addr_i == rcs_pkg::WDOG_VAL_OFS)   ? wdog_cnt_ff
                 : soft_rd;

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      reg_rdata_ff <= 32'h0000_0000;
    else
      reg_rdata_ff <= reg_rd_i ? rd_mux : 32'h0000_0000;
  end

  assign reg_rdata_o = reg_rdata_ff;
  assign droop_irq_o = droop_irq_ff;
  assign wdog_irq_o  = wdog_int_ff;
endmodule

// ### sim/rcs_ctrl_sva.sv
// Assertion checker for the reset and clock source controller
`timescale 1ns/1ps
module rcs_ctrl_sva #(
  parameter int NUM_SOFT = 3,
  parameter int NUM_DOM  = 2,
  parameter int PW       = NUM_DOM*NUM_SOFT*32
) (
  // Clock, reset and register port
  input wire logic          core_clk_i,
  input wire logic          resetn_i,
  input wire logic [7:0]    reg_addr_i,
  input wire logic [31:0]   reg_wdata_i,
  input wire logic          reg_wr_i,
  input wire logic          core_system_reset_request_i,
  // Outputs under watch
  input wire logic [1:0]    pll_ref_sel_o,
  input wire logic          pll_bypass_o,
  input wire logic [PW-1:0] periph_rst_n_o,
  input wire logic          core_rst_n_o,
  input wire logic          droop_irq_o,
  input wire logic          wdog_irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  wire logic cfg_wr  = reg_wr_i && reg_addr_i == rcs_pkg::CLK_CFG_OFS && core_rst_n_o;
  wire logic srst_wr = reg_wr_i && reg_addr_i == rcs_pkg::SOFT_RST0_OFS && core_rst_n_o;
  swreq_rst_a: assert property (
    core_system_reset_request_i && core_rst_n_o |-> ##[1:3] !core_rst_n_o) else $error("no reset");
  rst_hold_a: assert property (
    $fell(core_rst_n_o) |=> !core_rst_n_o [*8]) else $error("reset too short");
  rst_release_a: assert property (
    $fell(core_rst_n_o) |-> ##[16:40] core_rst_n_o) else $error("reset not released");
  cfg_default_a: assert property (
    !core_rst_n_o |=> pll_bypass_o && pll_ref_sel_o == 2'h0) else $error("clock cfg not default");
  cfg_write_a: assert property (
    cfg_wr |=> pll_ref_sel_o == $past(reg_wdata_i[5:4]) && pll_bypass_o == $past(reg_wdata_i[11]))
    else $error("clock cfg not taken");
  soft_on_a: assert property (
    srst_wr && reg_wdata_i[0] |-> ##[1:8] !periph_rst_n_o[0] && !periph_rst_n_o[NUM_SOFT*32])
    else $error("unit reset missing");
  soft_off_a: assert property (
    srst_wr && !reg_wdata_i[0] |-> ##[1:8] periph_rst_n_o[0]) else $error("unit reset stuck");
  wdog_irq_a: assert property (
    $rose(wdog_irq_o) |-> core_rst_n_o) else $error("first timeout reset");
  droop_irq_a: assert property (
    $rose(droop_irq_o) |-> core_rst_n_o) else $error("droop irq with reset");
  cover property ($rose(wdog_irq_o));
  cover property ($rose(droop_irq_o));
  cover property ($fell(core_rst_n_o));
endmodule
bind rcs_ctrl rcs_ctrl_sva #(.NUM_SOFT(NUM_SOFT), .NUM_DOM(NUM_DOM)) u_sva (.core_clk_i,
  .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .core_system_reset_request_i,
  .pll_ref_sel_o, .pll_bypass_o, .periph_rst_n_o, .core_rst_n_o, .droop_irq_o, .wdog_irq_o);

// ### sim/rcs_far_model.sv
// Far-side model: free-running oscillators and peripheral domain clocks
`timescale 1ns/1ps
module rcs_far_model (
  // Oscillators
  output logic       main_osc_o,
  output logic       rc_osc_o,
  output logic       pll_o,
  // Peripheral domain clocks
  output logic [1:0] periph_clk_o
);
  initial
  begin
    {main_osc_o, rc_osc_o, pll_o, periph_clk_o} = 5'h0;
    fork
      forever #62.5 main_osc_o = ~main_osc_o;
      forever #41.667 rc_osc_o = ~rc_osc_o;
      forever #10 pll_o = ~pll_o;
      forever #10 periph_clk_o[0] = ~periph_clk_o[0];
      forever #15 periph_clk_o[1] = ~periph_clk_o[1];
    join
  end
endmodule

// ### sim/rcs_ctrl_tb.sv
// Self-checking testbench for the reset and clock source controller
`timescale 1ns/1ps
module rcs_ctrl_tb;
  logic         clk, resetn, wr, rd, ext_n, droop, unreg, req, main_crystal_oscillator, rosc, pclk;
  logic         byp, sclk, core_n, dirq, wirq;
  logic [7:0]   addr;
  logic [31:0]  wdata, rdata;
  logic [1:0]   rsel, pclks;
  logic [191:0] prst_n;
  logic [5:0]   ecause;
  int           bad_count, compares, cycles, sedges;
  rcs_far_model far (.main_osc_o(main_crystal_oscillator), .rc_osc_o(rosc), .pll_o(pclk), .periph_clk_o(pclks));
  rcs_ctrl #(.HOLD_CYC(50)) dut (.core_clk_i(clk), .resetn_i(resetn), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .ext_rstn_i(ext_n),
    .droop_det_i(droop), .regulator_unreg_i(unreg), .core_system_reset_request_i(req),
    .main_crystal_oscillator_i(main_crystal_oscillator), .internal_rc_oscillator_i(rosc), .pll_clk_i(pclk),
    .pll_ref_sel_o(rsel), .pll_bypass_o(byp), .system_clock_out_o(sclk), .periph_clk_i(pclks),
    .periph_rst_n_o(prst_n), .core_rst_n_o(core_n), .droop_irq_o(dirq), .wdog_irq_o(wirq));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge sclk) sedges++;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic wcore(input logic v);
    for (int i = 0; i < 100 && core_n !== v; i++) @(posedge clk);
    chk(32'(core_n), 32'(v));
  endtask
  // Whole reset cycle, then the sticky cause word
  task automatic sysrst();
    wcore(1'b0);
    wcore(1'b1);
    rdc(rcs_pkg::CAUSE_OFS, 32'(ecause));
  endtask
  task automatic dpulse(input int n);
    @(posedge clk) droop <= 1'b1;
    repeat (n) @(posedge clk);
    droop <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_clk();
    int e0;
    for (int s = 0; s < 3; s++)
      for (int b = int'(s != 0); b < 2; b++)
      begin
        wrr(rcs_pkg::CLK_CFG_OFS, 32'(b * 2048 + s * 16));
        repeat (40) @(posedge clk);
        e0 = sedges;
        repeat (40) @(posedge clk);
        chk(32'({rsel, byp, sedges > e0}), 32'({s[1:0], b[0], 1'b1}));
      end
  endtask
  task automatic t_soft();
    wrr(rcs_pkg::SOFT_RST0_OFS, 32'h0000_0001);
    repeat (10) @(posedge clk);
    chk(32'({prst_n[96], prst_n[32], prst_n[1], prst_n[0]}), 32'h0000_0006);
    wrr(rcs_pkg::SOFT_RST0_OFS, 32'h0000_0000);
    repeat (10) @(posedge clk);
    chk(32'({prst_n[96], prst_n[0]}), 32'h0000_0003);
  endtask
  task automatic t_sw();
    @(posedge clk) req <= 1'b1;
    @(posedge clk) req <= 1'b0;
    ecause |= 6'h08;
    sysrst();
    rdc(rcs_pkg::CLK_CFG_OFS, rcs_pkg::CLK_CFG_RST);
  endtask
  task automatic t_droop();
    dpulse(20);
    rdc(rcs_pkg::STATUS_OFS, 32'h0000_0002);
    repeat (60) @(posedge clk);
    rdc(rcs_pkg::STATUS_OFS, 32'h0000_0000);
    chk(32'(dirq), 32'h0000_0000);
    rdc(rcs_pkg::CAUSE_OFS, 32'(ecause));
    wrr(rcs_pkg::SUPPLY_CTL_OFS, 32'h0001_0000);
    dpulse(20);
    chk(32'(dirq), 32'h0000_0001);
    repeat (60) @(posedge clk);
    wrr(rcs_pkg::STATUS_OFS, 32'h0000_0001);
    wrr(rcs_pkg::SUPPLY_CTL_OFS, 32'h0003_0000);
    dpulse(3);
    chk(32'(dirq), 32'h0000_0000);
    dpulse(20);
    chk(32'(dirq), 32'h0000_0001);
    repeat (60) @(posedge clk);
    wrr(rcs_pkg::SUPPLY_CTL_OFS, 32'h0000_0029);
    dpulse(3);
    repeat (60) @(posedge clk);
    rdc(rcs_pkg::CAUSE_OFS, 32'(ecause));
    wrr(rcs_pkg::SUPPLY_CTL_OFS, 32'h0000_0002);
    dpulse(3);
    ecause |= 6'h04;
    sysrst();
  endtask
  task automatic t_reg();
    @(posedge clk) unreg <= 1'b1;
    repeat (20) @(posedge clk);
    chk(32'(core_n), 32'h0000_0001);
    unreg <= 1'b0;
    wrr(rcs_pkg::REGULATOR_OFS, 32'h0000_0001);
    @(posedge clk) unreg <= 1'b1;
    repeat (3) @(posedge clk);
    unreg <= 1'b0;
    ecause |= 6'h20;
    sysrst();
  endtask
  task automatic t_wdog();
    int i;
    wrr(rcs_pkg::WDOG_LOAD_OFS, 32'h0000_001E);
    wrr(rcs_pkg::WDOG_CTL_OFS, 32'h0000_0003);
    for (i = 0; i < 100 && wirq !== 1'b1; i++) @(posedge clk);
    chk(32'(wirq), 32'h0000_0001);
    for (i = 0; i < 100 && core_n !== 1'b0; i++) @(posedge clk);
    chk(32'(i > 25 && i < 40), 32'h0000_0001);
    ecause |= 6'h10;
    sysrst();
  endtask
  task automatic t_ext();
    @(posedge clk) ext_n <= 1'b0;
    repeat (10) @(posedge clk);
    ext_n <= 1'b1;
    ecause = 6'h01;
    sysrst();
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    {resetn, ext_n, wr, rd, droop, unreg, req, addr, wdata} = 47'h2000_0000_0000;
    ecause = rcs_pkg::CAUSE_RST;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    wcore(1'b1);
    rdc(rcs_pkg::CAUSE_OFS, 32'(ecause));
    rdc(8'hFC, 32'h0000_0000);
    t_clk();
    t_soft();
    t_sw();
    t_droop();
    t_reg();
    t_wdog();
    t_ext();
    print_verdict();
  end
endmodule
